//--- design/irq_agg_pkg.sv
package irq_agg_pkg;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] STATUS0_OFFS      = 8'h00;
    localparam logic [7:0] STATUS1_OFFS      = 8'h04;
    localparam logic [7:0] HOST_EN0_OFFS     = 8'h08;
    localparam logic [7:0] HOST_EN1_OFFS     = 8'h0c;
    localparam logic [7:0] CPU_EN0_OFFS      = 8'h10;
    localparam logic [7:0] CPU_EN1_OFFS      = 8'h14;
    localparam logic [7:0] SRC_EN_OFFS       = 8'h18;
    localparam logic [7:0] SRC_STAT_OFFS     = 8'h1c;
    localparam logic [7:0] KEY_EN_OFFS       = 8'h20;
    localparam logic [7:0] KEY_STAT_OFFS     = 8'h24;
    localparam logic [7:0] TRIGGER_OFFS      = 8'h28;

    // ==========================================================
    // Status register 0 bit positions
    localparam int ST0_PANEL1 = 0;
    localparam int ST0_PANEL2 = 1;
    localparam int ST0_WDOG   = 2;
    localparam int ST0_ADMA   = 3;
    localparam int ST0_SDRAM  = 5;
    localparam int ST0_AUDIO  = 6;
    localparam int ST0_SPRITE = 7;

    // Status register 1 bit positions
    localparam int ST1_DMA0   = 0;
    localparam int ST1_DMA1   = 1;
    localparam int ST1_TIMER0 = 2;
    localparam int ST1_TIMER1 = 3;
    localparam int ST1_KEYPAD = 4;
    localparam int ST1_MANUAL = 7;

    // Source flag register positions (flags and their enables)
    localparam int SRC_SPRITE  = 0;
    localparam int SRC_FIFO_TH = 1;
    localparam int SRC_FIFO_OV = 2;
    localparam int SRC_FIFO_UN = 3;
    localparam int SRC_BUF0    = 4;
    localparam int SRC_BUF1    = 5;
    localparam int SRC_ADMA    = 6;
    localparam int SRC_PANEL1  = 7;
    localparam int SRC_PANEL2  = 8;
    localparam int SRC_W       = 9;

    localparam int KEY_N       = 25;
    localparam int TRIG_BIT    = 0;

    localparam logic [7:0]       STATUS_RST = 8'h00;
    localparam logic [7:0]       EN_RST     = 8'h00;
    localparam logic [SRC_W-1:0] SRC_RST    = 9'h000;
    localparam logic [KEY_N-1:0] KEY_RST    = 25'h0000000;

endpackage

//--- design/w1c_flags.sv
`timescale 1ns/1ps
module w1c_flags
    import irq_agg_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    output logic      [W-1:0] flags
);

    // ==========================================================
    // Sticky flags, set beats clear
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_flag
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    flags[i] <= 1'b0;
                end else begin
                    flags[i] <= set[i] | (flags[i] & ~clr[i]);
                end
            end
        end
    endgenerate

endmodule

//--- design/apb_regs.sv
`timescale 1ns/1ps
module apb_regs
    import irq_agg_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [31:0] rd_value,
    input  wire logic        rd_hit,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             wr_strobe,
    output logic             rd_strobe
);

    // ==========================================================
    // Single wait-free access: answer in the first access cycle
    wire access = psel & penable;

    assign pready    = 1'b1;
    assign wr_strobe = access & pwrite;
    assign rd_strobe = access & ~pwrite;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            prdata  <= (psel & ~penable & ~pwrite & rd_hit) ? rd_value
                                                             : prdata;
            pslverr <= 1'b0;
        end
    end

endmodule

//--- design/interrupt_status_aggregator.sv
// What this block does
// (R01) Sprite bit 7 of status 0: enabled sprite done; cleared at sprite flag
// (R02) Audio bit 6 is OR of enabled FIFO threshold, overrun, underrun flags
// (R03) SDRAM bit 5 is OR of enabled buffer 0 and 1 done flags
// (R04) Audio DMA bit 3 mirrors DMA flag and drives CPU line 3
// (R05) Watchdog bit 2 sets on expiry, write one clears, drives CPU line 2
// (R06) Second panel bit 1 is enabled vsync flag; cleared at the panel flag
// (R07) First panel bit 0 is enabled vsync flag; cleared at the panel flag
// (R08) Manual bit 7 of status 1 set by trigger write; host enable gates
// (R09) Bits 6 and 5 of status 1 reserved, read zero
// (R10) Keypad bit 4 set while any of 25 enabled key flags set
// (R11) Timer 1 bit 3 sets on enabled period end, unmasked, write one clears
// (R12) Raw flags; host enables route each source, CPU enables route all but watchdog and audio DMA
// (R13) Status 1 bits 1 and 0 hold DMA channel 1 and 0 done
// (R14) DMA done bits set on completion, unmasked, write one clears
// (R15) Timer 0 bit 2 sets on enabled period end, write one clears
// (R16) Writes to summary bits ignored; set beats simultaneous clear
`timescale 1ns/1ps
module interrupt_status_aggregator
    import irq_agg_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic             sprite_done,
    input  wire logic             fifo_threshold,
    input  wire logic             fifo_overrun,
    input  wire logic             fifo_underrun,
    input  wire logic             buf0_done,
    input  wire logic             buf1_done,
    input  wire logic             audio_dma_switch,
    input  wire logic             watchdog_expired,
    input  wire logic             first_panel_output_vsync,
    input  wire logic             second_panel_output_vsync,
    input  wire logic [KEY_N-1:0] key_event,
    input  wire logic             timer0_elapsed,
    input  wire logic             timer1_elapsed,
    input  wire logic             timer0_enabled,
    input  wire logic             timer1_enabled,
    input  wire logic             dma0_done,
    input  wire logic             dma1_done,
    input  wire logic             cpu_manual_trigger,
    output logic                  host_irq,
    output logic      [7:0]       cpu_irq0,
    output logic      [7:0]       cpu_irq1,
    output logic                  apb_irq
);

    // ==========================================================
    // Reset release
    // Assert at once, release after two edges
    logic rst_a_reg;
    logic rst_n_reg;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_a_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_a_reg <= 1'b1;
            rst_n_reg <= rst_a_reg;
        end
    end

    // ==========================================================
    // Bus slave
    logic [31:0] rd_value;
    logic        wr_strobe;
    logic [31:0] prdata_int;
    logic        pready_int;
    logic        pslverr_int;

    apb_regs u_bus (
        .clk       (clk),
        .rst_n     (rst_n_reg),
        .psel      (psel),
        .penable   (penable),
        .pwrite    (pwrite),
        .paddr     (paddr),
        .pwdata    (pwdata),
        .rd_value  (rd_value),
        .rd_hit    (1'b1),
        .prdata    (prdata_int),
        .pready    (pready_int),
        .pslverr   (pslverr_int),
        .wr_strobe (wr_strobe),
        .rd_strobe ()
    );

    assign prdata  = prdata_int;
    assign pready  = pready_int;
    assign pslverr = pslverr_int;

    wire wr_st0   = wr_strobe & (paddr == STATUS0_OFFS);
    wire wr_st1   = wr_strobe & (paddr == STATUS1_OFFS);
    wire wr_hen0  = wr_strobe & (paddr == HOST_EN0_OFFS);
    wire wr_hen1  = wr_strobe & (paddr == HOST_EN1_OFFS);
    wire wr_cen0  = wr_strobe & (paddr == CPU_EN0_OFFS);
    wire wr_cen1  = wr_strobe & (paddr == CPU_EN1_OFFS);
    wire wr_srcen = wr_strobe & (paddr == SRC_EN_OFFS);
    wire wr_srcst = wr_strobe & (paddr == SRC_STAT_OFFS);
    wire wr_keyen = wr_strobe & (paddr == KEY_EN_OFFS);
    wire wr_keyst = wr_strobe & (paddr == KEY_STAT_OFFS);
    wire wr_trig  = wr_strobe & (paddr == TRIGGER_OFFS);

    // ==========================================================
    // Enable registers
    logic [7:0]       host_en0_reg;
    logic [7:0]       host_en1_reg;
    logic [7:0]       cpu_en0_reg;
    logic [7:0]       cpu_en1_reg;
    logic [SRC_W-1:0] src_en_reg;
    logic [KEY_N-1:0] key_en_reg;

    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            host_en0_reg <= EN_RST;
            host_en1_reg <= EN_RST;
            cpu_en0_reg  <= EN_RST;
            cpu_en1_reg  <= EN_RST;
            src_en_reg   <= SRC_RST;
            key_en_reg   <= KEY_RST;
        end else begin
            if (wr_hen0)  host_en0_reg <= pwdata[7:0];
            if (wr_hen1)  host_en1_reg <= pwdata[7:0];
            if (wr_cen0)  cpu_en0_reg  <= pwdata[7:0];
            if (wr_cen1)  cpu_en1_reg  <= pwdata[7:0];
            if (wr_srcen) src_en_reg   <= pwdata[SRC_W-1:0];
            if (wr_keyen) key_en_reg   <= pwdata[KEY_N-1:0];
        end
    end

    // ==========================================================
    // Underlying source flags (write one to clear)
    logic [SRC_W-1:0] src_flags;
    logic [KEY_N-1:0] key_flags;
    logic [SRC_W-1:0] src_set;

    assign src_set[SRC_SPRITE]  = sprite_done;
    assign src_set[SRC_FIFO_TH] = fifo_threshold;
    assign src_set[SRC_FIFO_OV] = fifo_overrun;
    assign src_set[SRC_FIFO_UN] = fifo_underrun;
    assign src_set[SRC_BUF0]    = buf0_done;
    assign src_set[SRC_BUF1]    = buf1_done;
    assign src_set[SRC_ADMA]    = audio_dma_switch;
    assign src_set[SRC_PANEL1]  = first_panel_output_vsync;
    assign src_set[SRC_PANEL2]  = second_panel_output_vsync;

    // Ones in the write data clear, zeros keep
    wire [SRC_W-1:0] src_clr = wr_srcst ? pwdata[SRC_W-1:0] : SRC_RST;
    wire [KEY_N-1:0] key_clr = wr_keyst ? pwdata[KEY_N-1:0] : KEY_RST;

    w1c_flags #(.W(SRC_W)) u_src (
        .clk   (clk),
        .rst_n (rst_n_reg),
        .set   (src_set),
        .clr   (src_clr),  // see (R16)
        .flags (src_flags)
    );

    w1c_flags #(.W(KEY_N)) u_key (
        .clk   (clk),
        .rst_n (rst_n_reg),
        .set   (key_event),
        .clr   (key_clr),
        .flags (key_flags)
    );

    // ==========================================================
    // Summary bits of status 0 and 1
    wire [SRC_W-1:0] src_gated = src_flags & src_en_reg;

    wire sum_sprite = src_gated[SRC_SPRITE];  // see (R01)
    wire sum_audio  = src_gated[SRC_FIFO_TH] | src_gated[SRC_FIFO_OV]
                    | src_gated[SRC_FIFO_UN];  // see (R02)
    wire sum_sdram  = src_gated[SRC_BUF0] | src_gated[SRC_BUF1];  // see (R03)
    wire sum_adma   = src_flags[SRC_ADMA];  // see (R04)
    wire sum_panel2 = src_gated[SRC_PANEL2];  // see (R06)
    wire sum_panel1 = src_gated[SRC_PANEL1];  // see (R07)
    wire sum_keypad = |(key_flags & key_en_reg);  // see (R10)

    // ==========================================================
    // Own write-one-to-clear bits
    logic [7:0] own0_set;
    logic [7:0] own1_set;
    logic [7:0] own0_flags;
    logic [7:0] own1_flags;

    always_comb begin
        own0_set           = 8'h00;
        own0_set[ST0_WDOG] = watchdog_expired;  // see (R05)
        own1_set             = 8'h00;
        own1_set[ST1_DMA0]   = dma0_done;  // see (R13) see (R14)
        own1_set[ST1_DMA1]   = dma1_done;  // see (R13) see (R14)
        own1_set[ST1_TIMER0] = timer0_enabled & timer0_elapsed;  // see (R15)
        own1_set[ST1_TIMER1] = timer1_enabled & timer1_elapsed;  // see (R11)
        own1_set[ST1_MANUAL] = cpu_manual_trigger
                             | (wr_trig & pwdata[TRIG_BIT]);  // see (R08)
    end

    wire [7:0] own0_mask = 8'h00 | (8'h01 << ST0_WDOG);
    wire [7:0] own1_mask = (8'h01 << ST1_DMA0) | (8'h01 << ST1_DMA1)
                         | (8'h01 << ST1_TIMER0) | (8'h01 << ST1_TIMER1)
                         | (8'h01 << ST1_MANUAL);

    // Only own bits take a clear; summary bits ignore writes
    wire [7:0] own0_clr = wr_st0 ? (pwdata[7:0] & own0_mask)
                                 : 8'h00;  // see (R16)
    wire [7:0] own1_clr = wr_st1 ? (pwdata[7:0] & own1_mask) : 8'h00;

    w1c_flags #(.W(8)) u_own0 (
        .clk   (clk),
        .rst_n (rst_n_reg),
        .set   (own0_set),
        .clr   (own0_clr),
        .flags (own0_flags)
    );

    w1c_flags #(.W(8)) u_own1 (
        .clk   (clk),
        .rst_n (rst_n_reg),
        .set   (own1_set),
        .clr   (own1_clr),
        .flags (own1_flags)
    );

    logic [7:0] status0;
    logic [7:0] status1;

    // Summary bits are live ORs, not stored
    always_comb begin
        status0             = 8'h00;
        status0[ST0_PANEL1] = sum_panel1;
        status0[ST0_PANEL2] = sum_panel2;
        status0[ST0_WDOG]   = own0_flags[ST0_WDOG];
        status0[ST0_ADMA]   = sum_adma;
        status0[ST0_SDRAM]  = sum_sdram;
        status0[ST0_AUDIO]  = sum_audio;
        status0[ST0_SPRITE] = sum_sprite;
        status1             = own1_flags & own1_mask;  // see (R09)
        status1[ST1_KEYPAD] = sum_keypad;
    end

    // ==========================================================
    // Read mux
    always_comb begin
        unique case (paddr)
            STATUS0_OFFS:  rd_value = {24'h000000, status0};
            STATUS1_OFFS:  rd_value = {24'h000000, status1};
            HOST_EN0_OFFS: rd_value = {24'h000000, host_en0_reg};
            HOST_EN1_OFFS: rd_value = {24'h000000, host_en1_reg};
            CPU_EN0_OFFS:  rd_value = {24'h000000, cpu_en0_reg};
            CPU_EN1_OFFS:  rd_value = {24'h000000, cpu_en1_reg};
            SRC_EN_OFFS:   rd_value = {23'h000000, src_en_reg};
            SRC_STAT_OFFS: rd_value = {23'h000000, src_flags};
            KEY_EN_OFFS:   rd_value = {7'h00, key_en_reg};
            KEY_STAT_OFFS: rd_value = {7'h00, key_flags};
            default:       rd_value = 32'h00000000;
        endcase
    end

    // ==========================================================
    // Routing to host and embedded CPU
    logic [7:0] cpu_route0;
    logic [7:0] cpu_route1;
    logic [7:0] host_route0;
    logic [7:0] host_route1;

    always_comb begin
        cpu_route0           = status0 & cpu_en0_reg;  // see (R12)
        cpu_route0[ST0_ADMA] = status0[ST0_ADMA];  // see (R04)
        cpu_route0[ST0_WDOG] = status0[ST0_WDOG];  // see (R05)
    end

    assign cpu_route1  = status1 & cpu_en1_reg;   // see (R12)
    assign host_route0 = status0 & host_en0_reg;  // see (R12)
    assign host_route1 = status1 & host_en1_reg;  // see (R08)

    // Manual bit reaches the host only through its enable
    wire host_next = (|host_route0) | (|host_route1);

    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            host_irq <= 1'b0;
            cpu_irq0 <= STATUS_RST;
            cpu_irq1 <= STATUS_RST;
            apb_irq  <= 1'b0;
        end else begin
            host_irq <= host_next;
            cpu_irq0 <= cpu_route0;
            cpu_irq1 <= cpu_route1;
            apb_irq  <= host_next;
        end
    end

endmodule

//--- tb/irq_agg_checker.sv
`timescale 1ns/1ps
module irq_agg_checker
    import irq_agg_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic        watchdog_expired,
    input  wire logic        audio_dma_switch,
    input  wire logic        host_irq,
    input  wire logic        apb_irq,
    input  wire logic [7:0]  cpu_irq0
);
    // ==========
    // Bus and interrupt checks
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire rd_setup = psel && !penable && !pwrite;
    wire wr_acc   = psel && penable && pwrite;

    AST_READY: assert property (pready)
        else $error("pready low");
    AST_NO_ERR: assert property (!pslverr)
        else $error("pslverr raised");
    AST_WDOG_SET: assert property (
        watchdog_expired |-> ##2 cpu_irq0[2])
        else $error("watchdog not routed to cpu line 2");
    AST_WDOG_CAUSE: assert property (
        $rose(cpu_irq0[2]) |-> $past(watchdog_expired, 2))
        else $error("cpu line 2 rose without watchdog");
    AST_ADMA_SET: assert property (
        audio_dma_switch |-> ##2 cpu_irq0[3])
        else $error("audio dma not routed to cpu line 3");
    AST_ADMA_CAUSE: assert property (
        $rose(cpu_irq0[3]) |-> $past(audio_dma_switch, 2))
        else $error("cpu line 3 rose without audio dma");
    AST_IRQ_COPY: assert property (apb_irq == host_irq)
        else $error("apb_irq differs from host_irq");
    AST_UNMAPPED: assert property (
        rd_setup && paddr >= 8'h2c |=> prdata == 32'h0)
        else $error("unmapped read not zero");
    AST_RSVD: assert property (
        rd_setup && paddr == STATUS1_OFFS |=> prdata[6:5] == 2'b00)
        else $error("reserved status bits set");
    AST_HOST_FALL: assert property (
        $fell(host_irq) |-> $past(wr_acc, 2))
        else $error("host_irq fell without a write");

    cover property (watchdog_expired);
    cover property ($rose(host_irq));
    cover property (rd_setup && paddr == STATUS1_OFFS);
endmodule

bind interrupt_status_aggregator irq_agg_checker chk_u (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .watchdog_expired(watchdog_expired),
    .audio_dma_switch(audio_dma_switch), .host_irq(host_irq),
    .apb_irq(apb_irq), .cpu_irq0(cpu_irq0)
);

//--- tb/irq_sink.sv
`timescale 1ns/1ps
module irq_sink (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       host_irq,
    output logic      [7:0] host_raises
);
    logic prev_reg;
    // ==========
    // Host interrupt input, counts level rises
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_reg    <= 1'b0;
            host_raises <= 8'h00;
        end else begin
            prev_reg <= host_irq;
            if (host_irq && !prev_reg)
                host_raises <= host_raises + 8'h01;
        end
    end
endmodule

//--- tb/interrupt_status_aggregator_test.sv
`timescale 1ns/1ps
`define chk(got, exp) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        bad_count++; \
        $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); \
    end \
end
module interrupt_status_aggregator_test
    import irq_agg_pkg::*;
();
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, host_irq, apb_irq;
    logic [7:0]  cpu_irq0, cpu_irq1, host_raises;
    logic [14:0] ev = 15'h0;
    logic [24:0] keys = 25'h0;
    logic        t0en = 1'b0, t1en = 1'b0;
    int          bad_count = 0, samples_checked = 0;

    always #20 clk = ~clk;

    interrupt_status_aggregator dut_u (
        .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sprite_done(ev[0]), .fifo_threshold(ev[1]),
        .fifo_overrun(ev[2]), .fifo_underrun(ev[3]),
        .buf0_done(ev[4]), .buf1_done(ev[5]),
        .audio_dma_switch(ev[6]), .watchdog_expired(ev[7]),
        .first_panel_output_vsync(ev[8]),
        .second_panel_output_vsync(ev[9]), .key_event(keys),
        .timer0_elapsed(ev[10]), .timer1_elapsed(ev[11]),
        .timer0_enabled(t0en), .timer1_enabled(t1en),
        .dma0_done(ev[12]), .dma1_done(ev[13]),
        .cpu_manual_trigger(ev[14]), .host_irq(host_irq),
        .cpu_irq0(cpu_irq0), .cpu_irq1(cpu_irq1), .apb_irq(apb_irq)
    );

    irq_sink partner_u (
        .clk(clk), .arst_n(arst_n), .host_irq(host_irq),
        .host_raises(host_raises)
    );

    task automatic summarize();
        $display("mismatches %0d comparisons %0d", bad_count,
                 samples_checked);
        if (bad_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ==========
    // Bus cycle, optional events during the access phase
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [14:0] sev,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        ev      <= sev;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n == 16) begin
            bad_count++;
            summarize();
        end
        q = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        ev      <= 15'h0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, 15'h0, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, 15'h0, q);
        `chk(q, e)
    endtask

    task automatic pulse(input logic [14:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 15'h0;
    endtask

    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    // ==========
    // Scenarios
    task automatic t_reset();
        for (int i = 0; i < 12; i++)
            rd(8'(i * 4), 32'h0);
    endtask

    task automatic t_summary();
        wr(SRC_EN_OFFS, 32'h0);
        pulse(15'h0313);
        rd(STATUS0_OFFS, 32'h0);
        rd(SRC_STAT_OFFS, 32'h193);
        wr(SRC_EN_OFFS, 32'h1ff);
        rd(STATUS0_OFFS, 32'he3);
        pulse(15'h0040);
        rd(STATUS0_OFFS, 32'heb);
        `chk(cpu_irq0, 8'h08)
        wr(STATUS0_OFFS, 32'hff);
        rd(STATUS0_OFFS, 32'heb);
        wr(SRC_STAT_OFFS, 32'h010);
        rd(STATUS0_OFFS, 32'hcb);
        wr(SRC_STAT_OFFS, 32'h1ff);
        rd(STATUS0_OFFS, 32'h0);
    endtask

    task automatic t_wdog();
        pulse(15'h0080);
        rd(STATUS0_OFFS, 32'h04);
        `chk(cpu_irq0, 8'h04)
        `chk(host_irq, 1'b0)
        wr(HOST_EN0_OFFS, 32'h04);
        settle();
        `chk(host_irq, 1'b1)
        wr(STATUS0_OFFS, 32'h04);
        settle();
        `chk(host_irq, 1'b0)
        rd(STATUS0_OFFS, 32'h0);
        wr(HOST_EN0_OFFS, 32'h0);
    endtask

    task automatic t_status1();
        pulse(15'h0c00);
        rd(STATUS1_OFFS, 32'h0);
        @(posedge clk);
        t0en <= 1'b1;
        t1en <= 1'b1;
        pulse(15'h3c00);
        rd(STATUS1_OFFS, 32'h0f);
        wr(CPU_EN1_OFFS, 32'h01);
        settle();
        `chk(cpu_irq1, 8'h01)
        `chk(host_irq, 1'b0)
        wr(CPU_EN1_OFFS, 32'h0);
        wr(STATUS1_OFFS, 32'h0f);
        rd(STATUS1_OFFS, 32'h0);
    endtask

    task automatic t_keypad();
        wr(KEY_EN_OFFS, 32'h01000001);
        @(posedge clk);
        keys <= 25'h1000001;
        @(posedge clk);
        keys <= 25'h0;
        rd(STATUS1_OFFS, 32'h10);
        wr(STATUS1_OFFS, 32'h10);
        rd(STATUS1_OFFS, 32'h10);
        wr(KEY_STAT_OFFS, 32'h01000000);
        rd(STATUS1_OFFS, 32'h10);
        wr(KEY_STAT_OFFS, 32'h1);
        rd(STATUS1_OFFS, 32'h0);
    endtask

    task automatic t_manual();
        wr(TRIGGER_OFFS, 32'h1);
        settle();
        `chk(host_irq, 1'b0)
        rd(STATUS1_OFFS, 32'h80);
        wr(HOST_EN1_OFFS, 32'h80);
        settle();
        `chk(host_irq, 1'b1)
        wr(STATUS1_OFFS, 32'h80);
        wr(HOST_EN1_OFFS, 32'h0);
        rd(STATUS1_OFFS, 32'h0);
        pulse(15'h4000);
        rd(STATUS1_OFFS, 32'h80);
        wr(STATUS1_OFFS, 32'h80);
    endtask

    task automatic t_race();
        logic [31:0] q;
        pulse(15'h1000);
        apb(1'b1, STATUS1_OFFS, 32'h1, 15'h1000, q);
        rd(STATUS1_OFFS, 32'h01);
        wr(STATUS1_OFFS, 32'h1);
        rd(STATUS1_OFFS, 32'h0);
    endtask

    initial begin
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset();
        t_summary();
        t_wdog();
        t_status1();
        t_keypad();
        t_manual();
        t_race();
        `chk(host_raises, 8'h02)
        summarize();
    end
endmodule
